// File: design/effective_address_decoder.sv
// Effective address decoder: turns an address field and its extension into an operand.
`timescale 1ns/1ps
// What this block does
// - Size bit 0 byte, 1 word.
// - Register field selects R0 to R7.
// - 1010 register direct, 1101 indirect, no extension.
// - 1110 one-byte, 1111 two-byte displacement.
// - 1011 pre-decrement, no extension.
// - 1100 post-increment, no extension.
// - 04 byte immediate, 0c word immediate.
// - Short absolute offsets base page; long absolute.
// - PC-relative mode comes from opcode alone.
// - Minimum mode ignores page registers.
// - Page chosen by base register group.
// - Step one for byte, two for word.
// - Stack pointer always steps by two.
// - Odd word address raises address error.
// - Field and extension precede opcode byte.
module effective_address_decoder
    import ea_decode_pkg::*;
(
    // Clock and reset.
    input  wire logic                      ref_clk_i,
    input  wire logic                      sys_rst_i,
    // Instruction byte stream.
    input  wire logic                      byte_valid_i,
    input  wire logic [7:0]                byte_data_i,
    output logic                           byte_ready_o,
    // Special-format start: opcode already implies PC-relative.
    input  wire logic                      pcrel_start_i,
    input  wire logic                      pcrel_long_i,
    // CPU mode and page registers.
    input  wire logic                      minimum_mode_i,
    input  wire ea_decode_pkg::page_regs_t pages_i,
    // Register file read port.
    output logic [2:0]                     reg_rd_sel_o,
    input  wire logic [15:0]               reg_rd_data_i,
    input  wire logic [15:0]               pc_i,
    // Decoded operand to the memory access unit.
    output logic                           ea_valid_o,
    output ea_decode_pkg::ea_result_t      ea_o,
    output logic                           addr_error_o,
    input  wire logic                      ea_ready_i,
    input  wire logic                      access_done_i,
    // Register write-back of the stepped base register.
    output ea_decode_pkg::reg_update_t     reg_wr_o
);
    import ea_decode_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        ea_state_t   st;        // Sequencer state.
        logic [7:0]  field;     // Captured address field.
        ea_mode_t    mode;      // Decoded mode.
        logic [1:0]  ext_left;  // Extension bytes still to take.
        logic [15:0] ext;       // Assembled extension.
        ea_result_t  res;       // Result under offer.
        logic        err;       // Address error of the result.
        reg_update_t wr;        // Pending register write-back.
        logic [15:0] post_val;  // Value written after a post-increment access.
    } dec_state_t;

    dec_state_t cur;        // Registered state.
    dec_state_t next_cur;   // Next state.

    // ************************************************************
    // Field decode helpers
    // ************************************************************
    ea_mode_t    fmode;     // Mode of the incoming field.
    logic [1:0]  fext;      // Extension byte count of the incoming field.
    logic        wsize;     // Word operand of the captured field.
    logic [15:0] step;      // Step applied by pre/post modes.
    logic [7:0]  page_sel;  // Page chosen by the base register.
    logic [15:0] base_addr; // Address before page is attached.

    // Classify the incoming byte as an address field.
    always_comb
    begin
        fmode = MODE_NONE;
        fext  = 2'd0;
        if (byte_data_i == EA_IMM_BYTE)
        begin
            fmode = MODE_IMM8;
            fext  = 2'd1;
        end
        else if (byte_data_i == EA_IMM_WORD)
        begin
            fmode = MODE_IMM16;
            fext  = 2'd2;
        end
        else if (byte_data_i[2:0] == EA_ABS_LOW && byte_data_i[7:4] == EA_ABS_SHORT)
        begin
            fmode = MODE_ABS8;
            fext  = 2'd1;
        end
        else if (byte_data_i[2:0] == EA_ABS_LOW && byte_data_i[7:4] == EA_ABS_LONG)
        begin
            fmode = MODE_ABS16;
            fext  = 2'd2;
        end
        else
        begin
            unique case (byte_data_i[7:4])
                EA_REG_DIRECT:   fmode = MODE_REG;
                EA_REG_INDIRECT: fmode = MODE_INDIRECT;
                EA_PREDEC:       fmode = MODE_PREDEC;
                EA_POSTINC:      fmode = MODE_POSTINC;
                EA_DISP_SHORT:
                begin
                    fmode = MODE_DISP8;
                    fext  = 2'd1;
                end
                EA_DISP_LONG:
                begin
                    fmode = MODE_DISP16;
                    fext  = 2'd2;
                end
                default:         fmode = MODE_NONE;  // Not an address field.
            endcase
        end
    end

    // Size, step and page of the captured field.
    always_comb
    begin
        wsize = (cur.field[SIZE_BIT_POS] == SIZE_WORD);
        // The stack pointer is always a word access, so it must step by two.
        step  = (wsize || cur.field[2:0] == STACK_REG) ? STEP_WORD : STEP_BYTE;
        if (cur.field[2:0] <= DATA_PAGE_TOP)
            page_sel = pages_i.data_page_reg;
        else if (cur.field[2:0] <= EXTRA_PAGE_TOP)
            page_sel = pages_i.extra_page_reg;
        else
            page_sel = pages_i.stack_page_reg;
    end

    // Register read port always points at the captured register number.
    assign reg_rd_sel_o = cur.field[2:0];

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Field first, then extension bytes, then the operand is offered; opcode
    // bytes that follow are left to the opcode decoder.
    always_comb
    begin
        next_cur = cur;
        next_cur.wr.valid = 1'b0;
        base_addr = 16'h0000;
        unique case (cur.mode)
            MODE_INDIRECT, MODE_POSTINC: base_addr = reg_rd_data_i;
            MODE_PREDEC:  base_addr = reg_rd_data_i - step;
            MODE_DISP8:   base_addr = reg_rd_data_i + {{8{cur.ext[7]}}, cur.ext[7:0]};
            MODE_DISP16:  base_addr = reg_rd_data_i + cur.ext;
            MODE_ABS8:    base_addr = {8'h00, cur.ext[7:0]};
            MODE_ABS16:   base_addr = cur.ext;
            MODE_PCREL8:  base_addr = pc_i + {{8{cur.ext[7]}}, cur.ext[7:0]};
            MODE_PCREL16: base_addr = pc_i + cur.ext;
            default:      base_addr = 16'h0000;
        endcase
        unique case (cur.st)
            ST_FIELD:
            begin
                if (pcrel_start_i)
                begin
                    next_cur.mode     = pcrel_long_i ? MODE_PCREL16 : MODE_PCREL8;
                    next_cur.field    = 8'h00;
                    next_cur.ext_left = pcrel_long_i ? 2'd2 : 2'd1;
                    next_cur.ext      = 16'h0000;
                    next_cur.st       = ST_EXT_HI;
                end
                else if (byte_valid_i && fmode != MODE_NONE)
                begin
                    next_cur.field    = byte_data_i;
                    next_cur.mode     = fmode;
                    next_cur.ext_left = fext;
                    next_cur.ext      = 16'h0000;
                    next_cur.st       = (fext == 2'd0) ? ST_ISSUE : ST_EXT_HI;
                end
            end
            ST_EXT_HI:
            begin
                if (byte_valid_i)
                begin
                    // One-byte extensions land in the low byte.
                    if (cur.ext_left == 2'd2)
                        next_cur.ext[15:8] = byte_data_i;
                    else
                        next_cur.ext[7:0] = byte_data_i;
                    next_cur.ext_left = cur.ext_left - 2'd1;
                    next_cur.st = (cur.ext_left == 2'd2) ? ST_EXT_LO : ST_ISSUE;
                end
            end
            ST_EXT_LO:
            begin
                if (byte_valid_i)
                begin
                    next_cur.ext[7:0] = byte_data_i;
                    next_cur.ext_left = 2'd0;
                    next_cur.st       = ST_ISSUE;
                end
            end
            ST_ISSUE:
            begin
                next_cur.res.mode             = cur.mode;
                next_cur.res.operand_size_bit = cur.field[SIZE_BIT_POS];
                next_cur.res.reg_sel          = cur.field[2:0];
                next_cur.res.ext_value        = cur.ext;
                next_cur.res.address          = base_addr;
                next_cur.res.is_memory = !(cur.mode inside {MODE_REG, MODE_IMM8, MODE_IMM16});
                if (minimum_mode_i)
                    next_cur.res.page = 8'h00;
                else if (cur.mode == MODE_ABS8)
                    next_cur.res.page = pages_i.base_page_reg;
                else if (cur.mode inside {MODE_INDIRECT, MODE_DISP8, MODE_DISP16,
                                          MODE_PREDEC, MODE_POSTINC})
                    next_cur.res.page = page_sel;
                else
                    next_cur.res.page = 8'h00;
                // Stack-pointer stepping is a word access whatever the size.
                next_cur.err = next_cur.res.is_memory && base_addr[0] &&
                               (wsize || ((cur.mode inside {MODE_PREDEC, MODE_POSTINC})
                                          && cur.field[2:0] == STACK_REG));
                next_cur.wr.sel  = cur.field[2:0];
                next_cur.wr.value = base_addr;
                next_cur.wr.valid = (cur.mode == MODE_PREDEC);
                next_cur.post_val = reg_rd_data_i + step;
                next_cur.st = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (ea_ready_i && (!cur.res.is_memory || access_done_i))
                begin
                    if (cur.res.mode == MODE_POSTINC)
                    begin
                        next_cur.wr.valid = 1'b1;
                        next_cur.wr.value = cur.post_val;
                    end
                    next_cur.st = ST_FIELD;
                end
            end
            default: next_cur.st = ST_FIELD;
        endcase
    end

    // Register the whole state.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            cur <= '0;
        else
            cur <= next_cur;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign byte_ready_o = (cur.st == ST_FIELD) || (cur.st == ST_EXT_HI) || (cur.st == ST_EXT_LO);
    assign ea_valid_o   = (cur.st == ST_WAIT);
    assign ea_o         = cur.res;
    assign addr_error_o = (cur.st == ST_WAIT) && cur.err;
    assign reg_wr_o     = cur.wr;

    // Pre-decrement writes back one cycle after issue, before the access.
    a_predec_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (cur.st == ST_ISSUE && cur.mode == MODE_PREDEC) |=> reg_wr_o.valid)
        else $error("pre-decrement write-back missing");

    // Stack pointer steps by two.
    a_stack_step: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (cur.st == ST_ISSUE && cur.mode == MODE_POSTINC && cur.field[2:0] == 3'h7)
        |=> (cur.post_val == $past(reg_rd_data_i) + 16'h0002))
        else $error("stack pointer step is not two");

    // Minimum mode yields page zero.
    a_min_page: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (cur.st == ST_ISSUE && minimum_mode_i) |=> (ea_o.page == 8'h00))
        else $error("page used in minimum mode");

    // A byte pre-decrement of an ordinary register steps by one.
    a_byte_step: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (cur.st == ST_ISSUE && cur.mode == MODE_PREDEC && !cur.field[SIZE_BIT_POS]
         && cur.field[2:0] != 3'h7)
        |=> (reg_wr_o.value == $past(reg_rd_data_i) - 16'h0001))
        else $error("byte pre-decrement step is not one");

    // Registers six and seven take the stack page outside minimum mode.
    a_page_group: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (cur.st == ST_ISSUE && !minimum_mode_i && cur.mode == MODE_INDIRECT
         && cur.field[2:1] == 2'b11)
        |=> (ea_o.page == $past(pages_i.stack_page_reg)))
        else $error("stack page not chosen for registers six and seven");

    // Odd word address flags an error.
    a_odd_word: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (ea_valid_o && ea_o.is_memory && ea_o.operand_size_bit && ea_o.address[0])
        |-> addr_error_o)
        else $error("odd word address not flagged");

endmodule

// File: design/ea_decode_pkg.sv
// Package holding encodings, constants and carrier types of the effective address decoder.
package ea_decode_pkg;

    // ************************************************************
    // Field encodings
    // ************************************************************
    localparam logic [3:0] EA_REG_DIRECT   = 4'ha;  // Register direct.
    localparam logic [3:0] EA_REG_INDIRECT = 4'hd;  // Register indirect.
    localparam logic [3:0] EA_DISP_SHORT   = 4'he;  // Indirect plus one-byte displacement.
    localparam logic [3:0] EA_DISP_LONG    = 4'hf;  // Indirect plus two-byte displacement.
    localparam logic [3:0] EA_PREDEC       = 4'hb;  // Indirect with pre-decrement.
    localparam logic [3:0] EA_POSTINC      = 4'hc;  // Indirect with post-increment.
    localparam logic [7:0] EA_IMM_BYTE     = 8'h04; // Immediate, one extension byte.
    localparam logic [7:0] EA_IMM_WORD     = 8'h0c; // Immediate, two extension bytes.
    localparam logic [3:0] EA_ABS_SHORT    = 4'h0;  // Short absolute, top nibble.
    localparam logic [3:0] EA_ABS_LONG     = 4'h1;  // Long absolute, top nibble.
    localparam logic [2:0] EA_ABS_LOW      = 3'h5;  // Low three bits of absolute modes.

    // ************************************************************
    // Field positions and fixed values
    // ************************************************************
    localparam int         SIZE_BIT_POS = 3;      // Position of the operand size bit.
    localparam logic       SIZE_BYTE    = 1'b0;   // Size bit value for a byte operand.
    localparam logic       SIZE_WORD    = 1'b1;   // Size bit value for a word operand.
    localparam logic [2:0] STACK_REG    = 3'h7;   // Stack pointer register number.
    localparam logic [2:0] DATA_PAGE_TOP = 3'h3;  // Last register served by the data page.
    localparam logic [2:0] EXTRA_PAGE_TOP = 3'h5; // Last register served by the extra page.
    localparam logic [15:0] STEP_BYTE   = 16'h0001; // Byte step size.
    localparam logic [15:0] STEP_WORD   = 16'h0002; // Word step size.

    // Addressing mode of a decoded field.
    typedef enum logic [3:0] {
        MODE_NONE      = 4'h0,
        MODE_REG       = 4'h1,
        MODE_INDIRECT  = 4'h2,
        MODE_DISP8     = 4'h3,
        MODE_DISP16    = 4'h4,
        MODE_PREDEC    = 4'h5,
        MODE_POSTINC   = 4'h6,
        MODE_IMM8      = 4'h7,
        MODE_IMM16     = 4'h8,
        MODE_ABS8      = 4'h9,
        MODE_ABS16     = 4'ha,
        MODE_PCREL8    = 4'hb,
        MODE_PCREL16   = 4'hc
    } ea_mode_t;

    // Decoder states, Gray coded from ST_FIELD to ST_WAIT along the two-byte path.
    typedef enum logic [2:0] {
        ST_FIELD = 3'b000,
        ST_EXT_HI = 3'b001,
        ST_EXT_LO = 3'b011,
        ST_ISSUE = 3'b010,
        ST_WAIT  = 3'b110
    } ea_state_t;

    // Page registers handed in from the control registers.
    typedef struct packed {
        logic [7:0] data_page_reg;
        logic [7:0] extra_page_reg;
        logic [7:0] stack_page_reg;
        logic [7:0] base_page_reg;
    } page_regs_t;

    // Decoded operand handed to the execution side.
    typedef struct packed {
        ea_mode_t    mode;
        logic        operand_size_bit;
        logic [2:0]  reg_sel;
        logic [15:0] ext_value;
        logic [7:0]  page;
        logic [15:0] address;
        logic        is_memory;
    } ea_result_t;

    // Register write-back used by pre-decrement and post-increment.
    typedef struct packed {
        logic        valid;
        logic [2:0]  sel;
        logic [15:0] value;
    } reg_update_t;

endpackage

// File: test/ea_partner_model.sv
// Register file and memory access unit model on the far side of the decoder.
`timescale 1ns/1ps
module ea_partner_model
    import ea_decode_pkg::*;
(
    // Clock and reset.
    input  wire logic                       ref_clk_i,
    input  wire logic                       sys_rst_i,
    // Register file ports.
    input  wire logic [2:0]                 reg_rd_sel_i,
    output logic [15:0]                     reg_rd_data_o,
    input  wire ea_decode_pkg::reg_update_t reg_wr_i,
    // Memory access handshake.
    input  wire logic                       ea_valid_i,
    input  wire logic [2:0]                 stall_i,
    output logic                            ea_ready_o,
    output logic                            access_done_o
);
    logic [15:0] regs [8];  // General registers, preloaded by the bench.
    logic [2:0]  waited;    // Cycles the current operand has been held off.

    // The read port is combinational, as the decoder expects.
    assign reg_rd_data_o = regs[reg_rd_sel_i];

    // Stepped base registers land at the edge that sees the pulse.
    always @(posedge ref_clk_i)
    begin
        if (reg_wr_i.valid === 1'b1)
        begin
            regs[reg_wr_i.sel] <= reg_wr_i.value;
        end
    end

    // Accept after stall_i cycles; changes only on the falling edge so that
    // the decoder never sees a handshake move at its own sampling edge.
    always @(negedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ea_ready_o <= 1'b0;
            access_done_o <= 1'b0;
            waited <= 3'h0;
        end
        else if (ea_valid_i && !ea_ready_o && waited != stall_i)
        begin
            waited <= waited + 3'h1;
        end
        else
        begin
            ea_ready_o <= ea_valid_i && !ea_ready_o;
            access_done_o <= ea_valid_i && !ea_ready_o;
            waited <= 3'h0;
        end
    end
endmodule

// File: test/effective_address_decoder_tb_top.sv
// Self-checking bench for the effective address decoder.
`timescale 1ns/1ps
module effective_address_decoder_tb_top;
    import ea_decode_pkg::*;

    // Expected operand; the same layout serves as a mask of compared bits.
    typedef struct packed {
        ea_mode_t    mode;
        logic        size;
        logic [2:0]  sel;
        logic [7:0]  page;
        logic [15:0] addr;
        logic        mem;
        logic        err;
    } exp_t;

    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic byte_valid_i = 1'b0;
    logic [7:0] byte_data_i = 8'h00;
    logic pcrel_start_i = 1'b0;
    logic pcrel_long_i = 1'b0;
    logic minimum_mode_i = 1'b0;
    page_regs_t pages_i = '0;
    logic [15:0] pc_i = 16'h0000;
    logic [2:0] stall = 3'h0;
    logic byte_ready_o, ea_valid_o, addr_error_o, ea_ready_i, access_done_i, was_valid;
    logic [2:0] reg_rd_sel_o;
    logic [15:0] reg_rd_data_i;
    ea_result_t ea_o;
    reg_update_t reg_wr_o;
    exp_t exp_q[$];
    exp_t mask_q[$];
    exp_t e_mon;
    exp_t m_mon;
    logic [15:0] mirror [8];
    logic [31:0] rng = 32'h0000002f;
    logic [7:0] kinds [11] = '{8'ha0, 8'hd0, 8'he0, 8'hf0, 8'hb0, 8'hc0,
                               8'h04, 8'h0c, 8'h05, 8'h15, 8'h00};
    int exts [11] = '{0, 0, 1, 2, 0, 0, 1, 2, 1, 2, 1};
    int miscompares = 0;
    int compares = 0;

    // Free-running 50 MHz clock.
    always #10 ref_clk_i = ~ref_clk_i;

    effective_address_decoder dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .byte_valid_i(byte_valid_i), .byte_data_i(byte_data_i), .byte_ready_o(byte_ready_o),
        .pcrel_start_i(pcrel_start_i), .pcrel_long_i(pcrel_long_i),
        .minimum_mode_i(minimum_mode_i), .pages_i(pages_i), .reg_rd_sel_o(reg_rd_sel_o),
        .reg_rd_data_i(reg_rd_data_i), .pc_i(pc_i), .ea_valid_o(ea_valid_o), .ea_o(ea_o),
        .addr_error_o(addr_error_o), .ea_ready_i(ea_ready_i),
        .access_done_i(access_done_i), .reg_wr_o(reg_wr_o));

    ea_partner_model partner (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .reg_rd_sel_i(reg_rd_sel_o), .reg_rd_data_o(reg_rd_data_i), .reg_wr_i(reg_wr_o),
        .ea_valid_i(ea_valid_o), .stall_i(stall), .ea_ready_o(ea_ready_i),
        .access_done_o(access_done_i));

    // Xorshift generator, seeded so every run repeats.
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // One comparison; a mismatch is reported at once.
    task automatic check(input logic [63:0] act, input logic [63:0] exp);
        compares++;
        if (act !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    // Works out the operand from the field and notes it; also steps the mirror.
    task automatic predict(input logic [7:0] f, input logic [15:0] x, input logic pcr);
        exp_t e;
        exp_t m;
        logic [15:0] rv;
        logic [15:0] st;
        logic [15:0] sx;
        rv = mirror[f[2:0]];
        st = (f[SIZE_BIT_POS] || f[2:0] == STACK_REG) ? STEP_WORD : STEP_BYTE;
        sx = (pcr && pcrel_long_i) ? x : {{8{x[7]}}, x[7:0]};
        e = '0;
        m = '1;
        e.size = f[SIZE_BIT_POS];
        e.sel = f[2:0];
        e.mem = 1'b1;
        e.addr = rv;
        e.page = minimum_mode_i ? 8'h00 : (f[2:0] <= DATA_PAGE_TOP) ? pages_i.data_page_reg :
                 (f[2:0] <= EXTRA_PAGE_TOP) ? pages_i.extra_page_reg : pages_i.stack_page_reg;
        case (pcr ? 4'h9 : f[7:4])
            4'h9: e.mode = pcrel_long_i ? MODE_PCREL16 : MODE_PCREL8;
            EA_REG_DIRECT: {e.mode, e.mem, e.page, m.addr} = {MODE_REG, 1'b0, 8'h00, 16'h0000};
            EA_REG_INDIRECT: e.mode = MODE_INDIRECT;
            EA_DISP_SHORT: {e.mode, e.addr} = {MODE_DISP8, rv + sx};
            EA_DISP_LONG: {e.mode, e.addr} = {MODE_DISP16, rv + x};
            EA_PREDEC: {e.mode, e.addr, mirror[f[2:0]]} = {MODE_PREDEC, rv - st, rv - st};
            EA_POSTINC: {e.mode, mirror[f[2:0]]} = {MODE_POSTINC, rv + st};
            default:
            begin
                // Page handling of these modes is left open, so it is not compared.
                e.mode = (f == EA_IMM_BYTE) ? MODE_IMM8 : (f == EA_IMM_WORD) ? MODE_IMM16 :
                         f[4] ? MODE_ABS16 : MODE_ABS8;
                e.addr = f[4] ? x : {pages_i.base_page_reg, x[7:0]};
                {m.page, m.sel} = '0;
                e.mem = (e.mode == MODE_ABS8 || e.mode == MODE_ABS16);
                m.addr = (e.mode == MODE_ABS8) ? 16'h00ff : e.mem ? 16'hffff : 16'h0000;
            end
        endcase
        e.err = e.mem & e.addr[0] & (e.size | ((f[7:4] == EA_PREDEC || f[7:4] == EA_POSTINC)
                & f[2:0] == STACK_REG));
        if (pcr)
        begin
            e.addr = pc_i + sx;
            m = '0;
            {m.mode, m.addr} = '1;
        end
        exp_q.push_back(e);
        mask_q.push_back(m);
    endtask

    // One byte held until the decoder takes it.
    task automatic send(input logic [7:0] b);
        int k;
        @(negedge ref_clk_i);
        byte_valid_i = 1'b1;
        byte_data_i = b;
        k = 0;
        do
        begin
            @(posedge ref_clk_i);
            k++;
        end
        while (byte_ready_o !== 1'b1 && k < 50);
    endtask

    // A whole transfer: field, extension, wait for the operand to be accepted.
    task automatic run_op(input logic [7:0] f, input logic [15:0] x, input int n,
                          input logic pcr, input logic junk);
        int k;
        @(negedge ref_clk_i);
        stall = 3'(rnd());
        minimum_mode_i = (rnd() % 4 == 0);
        pages_i = page_regs_t'(rnd());
        pc_i = 16'(rnd());
        pcrel_long_i = (n == 2);
        predict(f, x, pcr);
        if (junk) send(8'h00);  // A byte that decodes as no field must be ignored.
        if (pcr)
        begin
            @(negedge ref_clk_i);
            byte_valid_i = 1'b0;  // A stale junk byte must not pose as the first extension.
            pcrel_start_i = 1'b1;
            @(negedge ref_clk_i);
            pcrel_start_i = 1'b0;
        end
        else send(f);
        if (n == 2) send(x[15:8]);
        if (n > 0) send(x[7:0]);
        @(negedge ref_clk_i);
        byte_valid_i = 1'b0;
        k = 0;
        while (ea_valid_o !== 1'b1 && k < 60) @(posedge ref_clk_i) k++;
        while (ea_valid_o === 1'b1 && k < 60) @(posedge ref_clk_i) k++;
        repeat (2) @(posedge ref_clk_i);
        check(64'(k < 60), 64'h1);
        check(64'(partner.regs[f[2:0]]), 64'(mirror[f[2:0]]));
    endtask

    // Takes the oldest note off the queue whenever an operand appears.
    always @(posedge ref_clk_i)
    begin
        was_valid <= ea_valid_o;
        if (ea_valid_o === 1'b1 && was_valid !== 1'b1)
        begin
            if (exp_q.size() == 0) check(64'h1, 64'h0);
            e_mon = exp_q.pop_front();
            m_mon = mask_q.pop_front();
            check(64'(exp_t'({ea_o.mode, ea_o.operand_size_bit, ea_o.reg_sel, ea_o.page,
                  ea_o.address, ea_o.is_memory, addr_error_o}) & m_mon), 64'(e_mon & m_mon));
        end
    end

    // Main sequence: step corner cases of the stack pointer and of R0 first, then random fields.
    initial
    begin
        int k;
        logic [31:0] r;
        logic [7:0] f;
        for (k = 0; k < 8; k++) mirror[k] = 16'(rnd());
        for (k = 0; k < 8; k++) partner.regs[k] = mirror[k];
        repeat (4) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        run_op(8'hb7, 16'h0000, 0, 1'b0, 1'b0);
        run_op(8'hc7, 16'h0000, 0, 1'b0, 1'b1);
        run_op(8'hc0, 16'h0000, 0, 1'b0, 1'b0);
        for (int i = 0; i < 300; i++)
        begin
            r = rnd();
            k = (i < 11) ? i : int'(r % 11);
            f = kinds[k];
            if (k < 6) f[3:0] = r[11:8];
            if (k == 8 || k == 9) f[SIZE_BIT_POS] = r[11];
            run_op(f, 16'(rnd()), (k == 10) ? 1 + int'(r[12]) : exts[k], k == 10, r[13]);
        end
        end_sim();
    end

    // Cuts a hang short well after the expected run time.
    initial
    begin
        #1000000;
        miscompares++;
        end_sim();
    end

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
endmodule
